// ===== cfa_params.svh
// Constants for the counter array control and mode register block.
// Assumes an SFR-style byte bus with address, write strobe and read data.
// Summary of operation
// - Counter runs while counter_run is 1 or the watchdog is on, unless idle suspend holds it; it stops otherwise.
// - Control bits 5..3 always read zero; writes to them are ignored.
// - Module 2 match or capture sets its flag and may request the interrupt.
// - Module 1 match or capture sets its flag and may request the interrupt.
// - Hardware never clears a match flag; only software clears it.
// - Counter wrap from 0xFFFF to 0x0000 sets the overflow flag.
// - After any reset the module 2 watchdog function is enabled.
`ifndef CFA_PARAMS_SVH
`define CFA_PARAMS_SVH
`define CFA_ADDR_CTRL     8'hD8
`define CFA_ADDR_MODE     8'hD9
`define CFA_MODE_RESET    8'h40
`define CFA_CTRL_RESET    8'h00
`define CFA_BIT_OVF       7
`define CFA_BIT_RUN       6
`define CFA_BIT_F2        2
`define CFA_BIT_F1        1
`define CFA_BIT_F0        0
`define CFA_BIT_IDLE      7
`define CFA_BIT_WDEN      6
`define CFA_BIT_WDLOCK    5
`define CFA_BIT_OVFIE     0
`define CFA_MODE_WMASK    8'hE1
`define CFA_CNT_MAX       16'hFFFF
`endif

// ===== cfa_pkg.sv
// Types for the counter array control and mode register block.
// Assumes cfa_params.svh supplies the numeric constants.
package cfa_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } cfa_bus_t;
  typedef struct packed {
    logic        run;
    logic        ovf;
    logic [2:0]  flags;
    logic [7:0]  mode;
    logic [15:0] count;
    logic [7:0]  rdata;
  } cfa_state_t;
endpackage

// ===== cfa_control.sv
// Control/flag and mode registers of the counter array, with its 16-bit counter.
// Assumes events and the bus come from logic on clk_sys; interrupt enables per module.
`timescale 1ns/10ps
`default_nettype none
`include "cfa_params.svh"
module cfa_control
  import cfa_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire cfa_bus_t   bus,
  input  wire logic       countTick,
  input  wire logic       idleMode,
  input  wire logic [2:0] matchEvent,
  input  wire logic [2:0] matchIrqEnable,
  output logic [7:0]      rdata,
  output logic [15:0]     count,
  output logic            watchdogEnable,
  output logic            counterRunning,
  output logic            irqRequest
);
  cfa_state_t st;
  cfa_state_t next_st;
  logic       wrCtrl;
  logic       wrMode;
  logic       countEn;
  logic       wrap;
  logic       locked;

  function automatic logic [7:0] readMux(input cfa_state_t s, input logic [7:0] a);
    if (a == `CFA_ADDR_CTRL)
      return {s.ovf, s.run, 3'h0, s.flags};
    else if (a == `CFA_ADDR_MODE)
      return s.mode;
    else
      return 8'h00;
  endfunction

  // Watchdog is on while either its enable or its lock bit is set
  function automatic logic wdActive(input logic [7:0] m);
    return m[`CFA_BIT_WDEN] | m[`CFA_BIT_WDLOCK];
  endfunction

  assign locked  = st.mode[`CFA_BIT_WDLOCK];
  // Watchdog forces the counter on; idle suspend holds it
  assign countEn = (st.run | wdActive(st.mode))
                   & ~(idleMode & st.mode[`CFA_BIT_IDLE]) & countTick;
  assign wrap    = countEn && (st.count == `CFA_CNT_MAX);
  assign wrCtrl  = bus.wr && (bus.addr == `CFA_ADDR_CTRL);
  assign wrMode  = bus.wr && (bus.addr == `CFA_ADDR_MODE);

  always_comb begin
    next_st = st;
    if (countEn) begin
      next_st.count = st.count + 16'h0001;
    end
    if (wrCtrl) begin
      next_st.run = bus.wdata[`CFA_BIT_RUN];
      // Zero clears, one keeps; set below wins over clear
      next_st.ovf   = st.ovf & bus.wdata[`CFA_BIT_OVF];
      next_st.flags = st.flags & bus.wdata[2:0];
    end
    if (wrMode) begin
      next_st.mode = bus.wdata & `CFA_MODE_WMASK;
      if (locked) begin
        next_st.mode[`CFA_BIT_IDLE]   = st.mode[`CFA_BIT_IDLE];
        next_st.mode[`CFA_BIT_WDEN]   = st.mode[`CFA_BIT_WDEN];
        next_st.mode[`CFA_BIT_WDLOCK] = 1'b1;
      end
    end
    if (wrap) begin
      next_st.ovf = 1'b1;
    end
    next_st.flags = next_st.flags | matchEvent;
    next_st.rdata = readMux(next_st, bus.addr);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st       <= '0;
      st.mode  <= `CFA_MODE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata          = st.rdata;
  assign count          = st.count;
  assign watchdogEnable = wdActive(st.mode);
  assign counterRunning = countEn;
  assign irqRequest     = |(st.flags & matchIrqEnable)
                          | (st.ovf & st.mode[`CFA_BIT_OVFIE]);

  // Match flags: set by events, held until software writes zero
  chk_flag2_sets: assert property (@(posedge clk_sys) disable iff (rst)
    matchEvent[2] |=> st.flags[2])
    else $error("module 2 flag not set");

  chk_flag1_sets: assert property (@(posedge clk_sys) disable iff (rst)
    matchEvent[1] |=> st.flags[1])
    else $error("module 1 flag not set");

  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (st.flags[1] && !wrCtrl) |=> st.flags[1])
    else $error("flag cleared by hw");

  chk_flag2_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (st.flags[2] && !wrCtrl) |=> st.flags[2])
    else $error("module 2 flag cleared by hw");

  chk_flag0_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (st.flags[0] && !wrCtrl) |=> st.flags[0])
    else $error("module 0 flag cleared by hw");

  sequence matchOneQuiet;
    matchEvent[1] ##1 !wrCtrl;
  endsequence

  chk_flag1_holds: assert property (@(posedge clk_sys) disable iff (rst)
    matchOneQuiet |=> st.flags[1])
    else $error("module 1 flag lost");

  // Interrupt request follows the enabled flags
  chk_irq_flag2: assert property (@(posedge clk_sys) disable iff (rst)
    (st.flags[2] && matchIrqEnable[2]) |-> irqRequest)
    else $error("module 2 interrupt missing");

  chk_irq_flag1: assert property (@(posedge clk_sys) disable iff (rst)
    (st.flags[1] && matchIrqEnable[1]) |-> irqRequest)
    else $error("module 1 interrupt missing");

  chk_irq_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    ((st.flags & matchIrqEnable) == 3'h0 && !(st.ovf && st.mode[`CFA_BIT_OVFIE])) |-> !irqRequest)
    else $error("interrupt without cause");

  // Read data and reserved bits
  chk_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    $past(bus.addr) == `CFA_ADDR_CTRL |-> rdata[5:3] == 3'h0)
    else $error("reserved bits not zero");

  chk_mode_read: assert property (@(posedge clk_sys) disable iff (rst)
    (bus.addr == `CFA_ADDR_MODE) |=> rdata == st.mode)
    else $error("mode read data wrong");

  chk_other_read: assert property (@(posedge clk_sys) disable iff (rst)
    (bus.addr != `CFA_ADDR_CTRL && bus.addr != `CFA_ADDR_MODE) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // Counter run control, watchdog and idle suspend
  chk_run_stops: assert property (@(posedge clk_sys) disable iff (rst)
    (!st.run && !watchdogEnable) |=> $stable(st.count))
    else $error("counter moved");

  chk_count_step: assert property (@(posedge clk_sys) disable iff (rst)
    countEn |=> st.count == $past(st.count) + 16'h0001)
    else $error("counter did not advance");

  chk_run_written: assert property (@(posedge clk_sys) disable iff (rst)
    wrCtrl |=> st.run == $past(bus.wdata[`CFA_BIT_RUN]))
    else $error("run bit not written");

  chk_idle_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (idleMode && st.mode[`CFA_BIT_IDLE]) |-> !counterRunning)
    else $error("counter ran in idle");

  chk_wd_forces: assert property (@(posedge clk_sys) disable iff (rst)
    (watchdogEnable && countTick && !(idleMode && st.mode[`CFA_BIT_IDLE])) |-> counterRunning)
    else $error("watchdog did not force counting");

  chk_lock_stays: assert property (@(posedge clk_sys) disable iff (rst)
    locked |=> (locked && watchdogEnable))
    else $error("watchdog lock released");

  // Overflow flag
  chk_wrap_flag: assert property (@(posedge clk_sys) disable iff (rst)
    wrap |=> st.ovf && st.count == 16'h0000)
    else $error("overflow flag missing");

  sequence wrapQuiet;
    wrap ##1 !wrCtrl;
  endsequence

  chk_wrap_holds: assert property (@(posedge clk_sys) disable iff (rst)
    wrapQuiet |=> st.ovf)
    else $error("overflow flag lost");

  chk_ovf_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (st.ovf && !wrCtrl) |=> st.ovf)
    else $error("overflow flag cleared by hw");

  // Reset values and mode writes
  chk_reset_mode: assert property (@(posedge clk_sys)
    rst |=> st.mode == `CFA_MODE_RESET && watchdogEnable)
    else $error("mode reset wrong");

  chk_mode_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wrMode && !locked) |=> st.mode == ($past(bus.wdata) & `CFA_MODE_WMASK))
    else $error("mode write wrong");

  // Software writes: zero clears, one keeps
  chk_zero_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && !bus.wdata[0] && !matchEvent[0]) |=> !st.flags[0])
    else $error("write zero did not clear");

  chk_zero_clears1: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && !bus.wdata[1] && !matchEvent[1]) |=> !st.flags[1])
    else $error("write zero did not clear module 1");

  chk_zero_clears2: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && !bus.wdata[2] && !matchEvent[2]) |=> !st.flags[2])
    else $error("write zero did not clear module 2");

  chk_one_keeps: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && bus.wdata[2] && st.flags[2]) |=> st.flags[2])
    else $error("write one cleared a flag");

  chk_ovf_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (wrCtrl && !bus.wdata[`CFA_BIT_OVF] && !wrap) |=> !st.ovf)
    else $error("write zero did not clear overflow");

  sequence writeZeroOne;
    wrCtrl && !bus.wdata[1] && !matchEvent[1];
  endsequence

  sequence readCtrlQuiet;
    bus.addr == `CFA_ADDR_CTRL && !matchEvent[1];
  endsequence

  chk_clear_visible: assert property (@(posedge clk_sys) disable iff (rst)
    writeZeroOne ##1 readCtrlQuiet |=> !rdata[1])
    else $error("cleared flag still reads one");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the counter array control and mode registers.
// Assumes cfa_pkg, cfa_params.svh and cfa_control are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "cfa_params.svh"
module tb_top;
  import cfa_pkg::*;
  logic       clk_sys, rst, countTick, idleMode, watchdogEnable, counterRunning, irqRequest;
  logic [2:0] matchEvent, matchIrqEnable;
  logic [7:0] rdata;
  logic [15:0] count;
  cfa_bus_t   bus;
  int         mismatches, compares;
  cfa_control uut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .countTick(countTick),
    .idleMode(idleMode), .matchEvent(matchEvent), .matchIrqEnable(matchIrqEnable),
    .rdata(rdata), .count(count), .watchdogEnable(watchdogEnable),
    .counterRunning(counterRunning), .irqRequest(irqRequest));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys) bus = '{a, 1'b1, d};
    @(negedge clk_sys) bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys) bus = '{a, 1'b0, 8'h00};
    repeat (2) @(negedge clk_sys);
    check(rdata, exp);
  endtask
  task automatic t_reset;
    rd(`CFA_ADDR_MODE, `CFA_MODE_RESET);
    check(watchdogEnable, 1'b1);
    rd(`CFA_ADDR_CTRL, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_run;
    wr(`CFA_ADDR_MODE, 8'h00);
    repeat (5) @(negedge clk_sys) countTick = ~countTick;
    @(negedge clk_sys) countTick = 1'b0;
    check(count, 16'h0000);
    wr(`CFA_ADDR_CTRL, 8'h78);
    rd(`CFA_ADDR_CTRL, 8'h40);
    @(negedge clk_sys) countTick = 1'b1;
    repeat (5) @(negedge clk_sys);
    countTick = 1'b0;
    check(count, 16'h0005);
    $display("run test done");
  endtask
  task automatic t_flags;
    for (int i = 1; i < 3; i++) begin
      @(negedge clk_sys) matchEvent = 3'(1 << i);
      @(negedge clk_sys) matchEvent = 3'h0;
      repeat (8) @(negedge clk_sys);
      check(irqRequest, 1'b0);
      matchIrqEnable = 3'(1 << i);
      #1 check(irqRequest, 1'b1);
      wr(`CFA_ADDR_CTRL, 8'hFF);
      rd(`CFA_ADDR_CTRL, 8'(8'h40 | (1 << i)));
      wr(`CFA_ADDR_CTRL, 8'(~(1 << i)));
      rd(`CFA_ADDR_CTRL, 8'h40);
      check(irqRequest, 1'b0);
      matchIrqEnable = 3'h0;
    end
    $display("flag test done");
  endtask
  task automatic t_ovf;
    @(negedge clk_sys) countTick = 1'b1;
    repeat (65531) @(negedge clk_sys);
    countTick = 1'b0;
    check(count, 16'h0000);
    rd(`CFA_ADDR_CTRL, 8'hC0);
    $display("overflow test done");
  endtask
  task automatic t_mode;
    check(counterRunning, 1'b0);
    @(negedge clk_sys) countTick = 1'b1;
    #1 check(counterRunning, 1'b1);
    @(negedge clk_sys) countTick = 1'b0;
    check(irqRequest, 1'b0);
    wr(`CFA_ADDR_MODE, 8'h9F);
    rd(`CFA_ADDR_MODE, 8'h81);
    check(irqRequest, 1'b1);
    @(negedge clk_sys) {idleMode, countTick} = 2'b11;
    #1 check(counterRunning, 1'b0);
    repeat (3) @(negedge clk_sys);
    {idleMode, countTick} = 2'b00;
    check(count, 16'h0001);
    wr(`CFA_ADDR_CTRL, 8'h40);
    rd(`CFA_ADDR_CTRL, 8'h40);
    check(irqRequest, 1'b0);
    wr(`CFA_ADDR_CTRL, 8'h00);
    @(negedge clk_sys) countTick = 1'b1;
    #1 check(counterRunning, 1'b0);
    @(negedge clk_sys) countTick = 1'b0;
    wr(`CFA_ADDR_MODE, 8'h20);
    check(watchdogEnable, 1'b1);
    wr(`CFA_ADDR_MODE, 8'h00);
    rd(`CFA_ADDR_MODE, 8'h20);
    @(negedge clk_sys) countTick = 1'b1;
    #1 check(counterRunning, 1'b1);
    @(negedge clk_sys) countTick = 1'b0;
    rd(8'hD7, 8'h00);
    @(negedge clk_sys) rst = 1'b1;
    @(negedge clk_sys) rst = 1'b0;
    rd(`CFA_ADDR_MODE, `CFA_MODE_RESET);
    check(watchdogEnable, 1'b1);
    rd(`CFA_ADDR_CTRL, 8'h00);
    $display("mode test done");
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #(25 * 80000);
    mismatches++;
    end_sim();
  end
  initial begin
    {rst, countTick, idleMode, matchEvent, matchIrqEnable} = {1'b1, 8'h00};
    bus = '{8'h00, 1'b0, 8'h00};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    t_reset();
    t_run();
    t_flags();
    t_ovf();
    t_mode();
    end_sim();
  end
endmodule
`default_nettype wire
